// ### hdl/adcpc_pkg.sv
package adcpc_pkg;

  // Clock
  localparam int CLK_HZ        = 20_000_000;
  localparam int CLK_PERIOD_NS = 50;

  // Register offsets
  localparam logic [5:0] OFS_CONV_CTRL = 6'h01;
  localparam logic [5:0] OFS_EXC_CTRL  = 6'h03;
  localparam logic [5:0] OFS_BIAS_CTRL = 6'h04;

  // Reset values
  localparam logic [15:0] RST_CONV_CTRL = 16'h0000;
  localparam logic [23:0] RST_EXC_CTRL  = 24'h000000;
  localparam logic [15:0] RST_BIAS_CTRL = 16'h0000;

  // Converter control fields; bits 15:13 read as zero
  localparam int          CC_CLK_SEL_LSB = 0;
  localparam int          CC_MODE_LSB    = 2;
  localparam int          CC_PWR_LSB     = 6;
  localparam int          CC_FLAGS_LSB   = 8;
  localparam logic [15:0] CC_WMASK       = 16'h1fff;

  // Excitation and output control fields; bit 14 reads as zero
  localparam int          EX_PIN_A_LSB = 0;
  localparam int          EX_PIN_B_LSB = 4;
  localparam int          EX_LVL_A_LSB = 8;
  localparam int          EX_LVL_B_LSB = 11;
  localparam int          EX_BRIDGE    = 15;
  localparam int          EX_GP_EN_LSB = 16;
  localparam int          EX_GP_DT_LSB = 20;
  localparam logic [23:0] EX_WMASK     = 24'hffbfff;

  // Level codes: 0 off, 1..6 = 50, 100, 250, 500, 750 uA, 1 mA
  localparam logic [2:0] LVL_OFF = 3'h0;

  // Operating modes
  localparam logic [3:0] MODE_CONT    = 4'h0;
  localparam logic [3:0] MODE_STANDBY = 4'h2;
  localparam logic [3:0] MODE_PDOWN   = 4'h3;

  // Clock source select
  localparam logic [1:0] CLKSEL_INT     = 2'h0;
  localparam logic [1:0] CLKSEL_INT_OUT = 2'h1;

  // Power modes and master clock dividers minus one
  localparam logic [1:0] PWR_LOW      = 2'h0;
  localparam logic [1:0] PWR_MID      = 2'h1;
  localparam logic [2:0] DIVM1_FULL   = 3'h0;
  localparam logic [2:0] DIVM1_MID    = 3'h3;
  localparam logic [2:0] DIVM1_LOW    = 3'h7;

  // Oscillator: 614.4 kHz in tenths of Hz, toggled at twice that rate
  localparam int          OSC_HZ_X10 = 6_144_000;
  localparam logic [31:0] OSC_STEP   = 32'(2 * OSC_HZ_X10);
  localparam logic [31:0] OSC_MOD    = 32'(CLK_HZ * 10);

  // Timing
  localparam int STBY_WAKE_MCLK  = 130;
  localparam int SER_WAKE_CLKS   = 64;
  localparam int WAKE_SETTLE_NS  = 2_000_000;
  localparam int WAKE_SETTLE_CYC =
    (WAKE_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [4:0] {
    ST_SETTLE  = 5'b00001,
    ST_ACTIVE  = 5'b00010,
    ST_STANDBY = 5'b00100,
    ST_WAKE    = 5'b01000,
    ST_DOWN    = 5'b10000
  } adcpc_state_t;

endpackage : adcpc_pkg

// ### hdl/adcpc_sync3.sv
`timescale 1ns/10ps
module adcpc_sync3 #(
  parameter int W = 8
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         sys_rst,
  // Pin side
  input  wire logic [W-1:0] d_in,
  // Filtered level
  output logic      [W-1:0] q_out
);

  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;

  // A bit changes only once stages two and three agree
  genvar gi;
  generate
    for (gi = 0; gi < W; gi++) begin : g_bit
      always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
          s1_r[gi]  <= 1'b0;
          s2_r[gi]  <= 1'b0;
          s3_r[gi]  <= 1'b0;
          q_out[gi] <= 1'b0;
        end else begin
          s1_r[gi] <= d_in[gi];
          s2_r[gi] <= s1_r[gi];
          s3_r[gi] <= s2_r[gi];
          if (s2_r[gi] == s3_r[gi]) begin
            q_out[gi] <= s3_r[gi];
          end
        end
      end
    end
  endgenerate

endmodule : adcpc_sync3

// ### hdl/adcpc_ctrl.sv
`timescale 1ns/10ps
module adcpc_ctrl #(
  parameter int WAKE_SETTLE_CYC = adcpc_pkg::WAKE_SETTLE_CYC
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // Register access from the serial engine
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [5:0]  reg_addr,
  input  wire logic [23:0] reg_wdata,
  output logic      [23:0] reg_rdata,
  output logic             reg_rvalid,
  output logic             regs_ready,
  // Status flag
  output logic             por_flag,
  input  wire logic        por_flag_clr,
  // Serial pins, watched for the wake pattern
  input  wire logic        sclk_pin,
  input  wire logic        cs_n_pin,
  input  wire logic        din_pin,
  // Clock pin
  input  wire logic        ext_clk_pin,
  output logic             clk_pin_out,
  output logic             clk_pin_oe,
  output logic             mclk_tick,
  // Conversion results
  input  wire logic [23:0] conv_sample,
  input  wire logic        conv_bipolar,
  input  wire logic        conv_valid,
  output logic      [23:0] code_out,
  output logic             code_valid,
  // Analog controls
  output logic      [2:0]  current_a_level,
  output logic      [2:0]  current_b_level,
  output logic      [3:0]  current_a_pin_sel,
  output logic      [3:0]  current_b_pin_sel,
  output logic             bridge_switch_on,
  output logic      [15:0] bias_enable_bits,
  output logic             ref_enable,
  output logic      [4:0]  ctrl_flags,
  output logic      [3:0]  mode_out,
  output logic             conv_run,
  // General-purpose outputs
  output logic      [3:0]  gp_out_value,
  output logic      [3:0]  gp_out_oe,
  input  wire logic [3:0]  gp_pin_in,
  // Diagnostics needing the master clock
  input  wire logic        diag_mclk_req,
  output logic             diag_mclk_run
);

  localparam logic [15:0] SETTLE_LAST = 16'(WAKE_SETTLE_CYC - 1);
  localparam logic [15:0] STBY_LAST   = 16'(adcpc_pkg::STBY_WAKE_MCLK - 1);
  localparam logic [6:0]  SER_LAST    = 7'(adcpc_pkg::SER_WAKE_CLKS - 1);

  adcpc_pkg::adcpc_state_t state_r;
  adcpc_pkg::adcpc_state_t state_nxt;

  logic [15:0] conv_ctrl_r;
  logic [23:0] exc_ctrl_r;
  logic [15:0] bias_ctrl_r;
  logic [15:0] cnt_r;
  logic [6:0]  ser_cnt_r;
  logic [31:0] osc_acc_r;
  logic        osc_r;
  logic [2:0]  div_cnt_r;
  logic        sclk_d_r;
  logic        ext_d_r;
  logic        diag_blk_r;
  logic [7:0]  pins_q;

  // Synchronised pins
  adcpc_sync3 #(.W(8)) u_sync (
    .clk     (clk),
    .sys_rst (sys_rst),
    .d_in    ({gp_pin_in, ext_clk_pin, din_pin, cs_n_pin, sclk_pin}),
    .q_out   (pins_q)
  );

  wire       sclk_q   = pins_q[0];
  wire       cs_n_q   = pins_q[1];
  wire       din_q    = pins_q[2];
  wire       ext_q    = pins_q[3];
  wire [3:0] gp_q     = pins_q[7:4];

  wire       st_settle  = (state_r == adcpc_pkg::ST_SETTLE);
  wire       st_active  = (state_r == adcpc_pkg::ST_ACTIVE);
  wire       st_standby = (state_r == adcpc_pkg::ST_STANDBY);
  wire       st_wake    = (state_r == adcpc_pkg::ST_WAKE);
  wire       st_down    = (state_r == adcpc_pkg::ST_DOWN);
  wire       regs_ok    = st_active | st_standby | st_wake;

  // Control fields
  wire [1:0] clk_sel  = conv_ctrl_r[adcpc_pkg::CC_CLK_SEL_LSB +: 2];
  wire [3:0] mode_f   = conv_ctrl_r[adcpc_pkg::CC_MODE_LSB +: 4];
  wire [1:0] pwr_f    = conv_ctrl_r[adcpc_pkg::CC_PWR_LSB +: 2];
  wire       use_int  = (clk_sel == adcpc_pkg::CLKSEL_INT) |
                        (clk_sel == adcpc_pkg::CLKSEL_INT_OUT);
  wire       mode_sby = (mode_f == adcpc_pkg::MODE_STANDBY);
  wire       mode_pd  = (mode_f == adcpc_pkg::MODE_PDOWN);

  // Register writes
  wire        wr_ok    = reg_wr & regs_ok;
  wire        wr_cc    = wr_ok & (reg_addr == adcpc_pkg::OFS_CONV_CTRL);
  wire        wr_ex    = wr_ok & (reg_addr == adcpc_pkg::OFS_EXC_CTRL);
  wire        wr_bias  = wr_ok & (reg_addr == adcpc_pkg::OFS_BIAS_CTRL);
  wire [3:0]  new_mode = reg_wdata[adcpc_pkg::CC_MODE_LSB +: 4];
  // Power-down from any mode but standby keeps the previous mode
  wire        pd_bad   = (new_mode == adcpc_pkg::MODE_PDOWN) &
                         ~(st_standby & mode_sby);
  wire [15:0] cc_wr    = reg_wdata[15:0] & adcpc_pkg::CC_WMASK;
  wire [15:0] cc_nxt   = pd_bad ?
    {cc_wr[15:6], mode_f, cc_wr[1:0]} : cc_wr;

  // Internal oscillator as a fractional accumulator
  wire [31:0] osc_sum  = osc_acc_r + adcpc_pkg::OSC_STEP;
  wire        osc_wrap = (osc_sum >= adcpc_pkg::OSC_MOD);
  wire        osc_rise = osc_wrap & ~osc_r;
  wire        ext_rise = ext_q & ~ext_d_r;
  wire        src_tick = use_int ? osc_rise : ext_rise;

  // Power mode divider
  wire [2:0]  div_lim  = (pwr_f == adcpc_pkg::PWR_LOW) ? adcpc_pkg::DIVM1_LOW :
                         (pwr_f == adcpc_pkg::PWR_MID) ? adcpc_pkg::DIVM1_MID :
                         adcpc_pkg::DIVM1_FULL;
  // Compare by magnitude so a switch to a faster mode cannot stall the count
  wire        div_end  = (div_cnt_r >= div_lim);
  wire        mclk_nxt = src_tick & div_end & ~st_down;

  // Wake pattern: consecutive serial clocks with select low, data high
  wire        sclk_rise = sclk_q & ~sclk_d_r;
  wire        ser_one   = sclk_rise & ~cs_n_q & din_q;
  wire        ser_done  = st_down & ser_one & (ser_cnt_r == SER_LAST);

  wire        settle_done = st_settle & (cnt_r == SETTLE_LAST);
  wire        wake_done   = st_wake & mclk_tick & (cnt_r == STBY_LAST);

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      adcpc_pkg::ST_SETTLE: begin
        if (settle_done) begin
          state_nxt = adcpc_pkg::ST_ACTIVE;
        end
      end
      adcpc_pkg::ST_ACTIVE: begin
        if (mode_sby) begin
          state_nxt = adcpc_pkg::ST_STANDBY;
        end
      end
      adcpc_pkg::ST_STANDBY: begin
        if (mode_pd) begin
          state_nxt = adcpc_pkg::ST_DOWN;
        end else if (!mode_sby) begin
          state_nxt = adcpc_pkg::ST_WAKE;
        end
      end
      adcpc_pkg::ST_WAKE: begin
        if (mode_sby) begin
          state_nxt = adcpc_pkg::ST_STANDBY;
        end else if (wake_done) begin
          state_nxt = adcpc_pkg::ST_ACTIVE;
        end
      end
      adcpc_pkg::ST_DOWN: begin
        if (ser_done) begin
          state_nxt = adcpc_pkg::ST_SETTLE;
        end
      end
    endcase
  end

  // Counter shared by the settle and standby-exit waits
  wire [15:0] cnt_nxt =
    (state_nxt != state_r)  ? 16'h0000 :
    st_settle               ? cnt_r + 16'h0001 :
    (st_wake & mclk_tick)   ? cnt_r + 16'h0001 : cnt_r;

  wire [6:0] ser_nxt = !st_down ? 7'h00 :
                       cs_n_q   ? 7'h00 :
                       !sclk_rise ? ser_cnt_r :
                       din_q    ? ser_cnt_r + 7'h01 : 7'h00;

  // Standby forces the currents off; the reference enable plays no part
  wire       cur_off  = ~(st_active | st_settle);
  wire [2:0] lvl_a    = exc_ctrl_r[adcpc_pkg::EX_LVL_A_LSB +: 3];
  wire [2:0] lvl_b    = exc_ctrl_r[adcpc_pkg::EX_LVL_B_LSB +: 3];
  wire [3:0] gp_en    = exc_ctrl_r[adcpc_pkg::EX_GP_EN_LSB +: 4];
  wire [3:0] gp_dat   = exc_ctrl_r[adcpc_pkg::EX_GP_DT_LSB +: 4];

  // Read path: data bits show the pins, not the stored values
  wire [23:0] ex_rd   = {gp_q, exc_ctrl_r[19:0]};
  wire [23:0] rd_mux  =
    !regs_ok                                 ? 24'h000000 :
    (reg_addr == adcpc_pkg::OFS_CONV_CTRL)   ? {8'h00, conv_ctrl_r} :
    (reg_addr == adcpc_pkg::OFS_EXC_CTRL)    ? ex_rd :
    (reg_addr == adcpc_pkg::OFS_BIAS_CTRL)   ? {8'h00, bias_ctrl_r} :
    24'h000000;

  // Code formatting: offset binary is the two's complement with MSB flipped
  wire [23:0] code_nxt = conv_bipolar ?
    {~conv_sample[23], conv_sample[22:0]} :
    conv_sample;

  // Diagnostic switched on during standby stays blocked until switched off
  wire diag_blk_nxt = diag_mclk_req & (diag_blk_r | st_standby);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_r   <= adcpc_pkg::ST_SETTLE;
      cnt_r     <= 16'h0000;
      ser_cnt_r <= 7'h00;
      sclk_d_r  <= 1'b0;
      ext_d_r   <= 1'b0;
      diag_blk_r <= 1'b0;
    end else begin
      state_r   <= state_nxt;
      cnt_r     <= cnt_nxt;
      ser_cnt_r <= ser_nxt;
      sclk_d_r  <= sclk_q;
      ext_d_r   <= ext_q;
      diag_blk_r <= diag_blk_nxt;
    end
  end

  // Registers: held at reset values while powered down and while settling
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      conv_ctrl_r <= adcpc_pkg::RST_CONV_CTRL;
      exc_ctrl_r  <= adcpc_pkg::RST_EXC_CTRL;
      bias_ctrl_r <= adcpc_pkg::RST_BIAS_CTRL;
    end else if (st_down || st_settle) begin
      conv_ctrl_r <= adcpc_pkg::RST_CONV_CTRL;
      exc_ctrl_r  <= adcpc_pkg::RST_EXC_CTRL;
      bias_ctrl_r <= adcpc_pkg::RST_BIAS_CTRL;
    end else begin
      // Standby keeps every register as written
      if (wr_cc) begin
        conv_ctrl_r <= cc_nxt;
      end
      if (wr_ex) begin
        exc_ctrl_r <= reg_wdata & adcpc_pkg::EX_WMASK;
      end
      if (wr_bias) begin
        bias_ctrl_r <= reg_wdata[15:0];
      end
    end
  end

  // Oscillator stops in power-down, so its phase restarts on wake
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      osc_acc_r <= 32'h00000000;
      osc_r     <= 1'b0;
      div_cnt_r <= 3'h0;
    end else if (st_down) begin
      osc_acc_r <= 32'h00000000;
      osc_r     <= 1'b0;
      div_cnt_r <= 3'h0;
    end else begin
      osc_acc_r <= osc_wrap ? osc_sum - adcpc_pkg::OSC_MOD : osc_sum;
      osc_r     <= osc_r ^ osc_wrap;
      if (src_tick) begin
        div_cnt_r <= div_end ? 3'h0 : div_cnt_r + 3'h1;
      end
    end
  end

  // Output flops
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata         <= 24'h000000;
      reg_rvalid        <= 1'b0;
      regs_ready        <= 1'b0;
      por_flag          <= 1'b0;
      clk_pin_out       <= 1'b0;
      clk_pin_oe        <= 1'b0;
      mclk_tick         <= 1'b0;
      code_out          <= 24'h000000;
      code_valid        <= 1'b0;
      current_a_level   <= adcpc_pkg::LVL_OFF;
      current_b_level   <= adcpc_pkg::LVL_OFF;
      current_a_pin_sel <= 4'h0;
      current_b_pin_sel <= 4'h0;
      bridge_switch_on  <= 1'b0;
      bias_enable_bits  <= 16'h0000;
      ref_enable        <= 1'b0;
      ctrl_flags        <= 5'h00;
      mode_out          <= adcpc_pkg::MODE_CONT;
      conv_run          <= 1'b0;
      gp_out_value      <= 4'h0;
      gp_out_oe         <= 4'h0;
      diag_mclk_run     <= 1'b0;
    end else begin
      reg_rdata   <= reg_rd ? rd_mux : reg_rdata;
      reg_rvalid  <= reg_rd;
      regs_ready  <= regs_ok | settle_done;
      // Set wins over a clear in the same cycle
      por_flag    <= settle_done |
                     (por_flag & ~por_flag_clr & ~st_down);
      clk_pin_out <= osc_r;
      clk_pin_oe  <= (clk_sel == adcpc_pkg::CLKSEL_INT_OUT) & ~st_down;
      mclk_tick   <= mclk_nxt;
      code_out    <= conv_valid ? code_nxt : code_out;
      code_valid  <= conv_valid & st_active;
      current_a_level   <= cur_off ? adcpc_pkg::LVL_OFF : lvl_a;
      current_b_level   <= cur_off ? adcpc_pkg::LVL_OFF : lvl_b;
      current_a_pin_sel <= exc_ctrl_r[adcpc_pkg::EX_PIN_A_LSB +: 4];
      current_b_pin_sel <= exc_ctrl_r[adcpc_pkg::EX_PIN_B_LSB +: 4];
      bridge_switch_on  <= exc_ctrl_r[adcpc_pkg::EX_BRIDGE];
      bias_enable_bits  <= bias_ctrl_r;
      ref_enable        <= conv_ctrl_r[adcpc_pkg::CC_FLAGS_LSB];
      ctrl_flags        <= conv_ctrl_r[adcpc_pkg::CC_FLAGS_LSB +: 5];
      mode_out          <= mode_f;
      conv_run          <= st_active & ~settle_done;
      gp_out_value      <= gp_dat;
      gp_out_oe         <= st_down ? 4'h0 : gp_en;
      diag_mclk_run     <= diag_mclk_req & ~diag_blk_nxt & regs_ok;
    end
  end

endmodule : adcpc_ctrl

// ### bench/adcpc_ctrl_asserts.sv
`timescale 1ns/10ps
module adcpc_ctrl_asserts #(
  parameter int WAKE_SETTLE_CYC = 40000
) (
  // Clock and reset
  input wire logic        clk,
  input wire logic        sys_rst,
  // Register access
  input wire logic        reg_wr,
  input wire logic [5:0]  reg_addr,
  input wire logic [23:0] reg_wdata,
  input wire logic        regs_ready,
  input wire logic        por_flag,
  // Clock pin and master clock
  input wire logic        clk_pin_oe,
  input wire logic        mclk_tick,
  // Results
  input wire logic [23:0] conv_sample,
  input wire logic        conv_bipolar,
  input wire logic [23:0] code_out,
  input wire logic        code_valid,
  // Controls
  input wire logic [2:0]  current_a_level,
  input wire logic [2:0]  current_b_level,
  input wire logic [15:0] bias_enable_bits,
  input wire logic [3:0]  mode_out,
  input wire logic        conv_run,
  input wire logic [3:0]  gp_out_value,
  input wire logic [3:0]  gp_out_oe,
  input wire logic        diag_mclk_req,
  input wire logic        diag_mclk_run
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  wire logic [23:0] code_w = {conv_sample[23] ^ conv_bipolar,
                              conv_sample[22:0]};
  wire logic        stby_w = mode_out == adcpc_pkg::MODE_STANDBY;
  wire logic        clr_w  = conv_run || !regs_ready;
  wire logic        bias_w = reg_wr && regs_ready &&
                             reg_addr == adcpc_pkg::OFS_BIAS_CTRL;
  wire logic        exc_w  = reg_wr && regs_ready &&
                             reg_addr == adcpc_pkg::OFS_EXC_CTRL;
  // Standby time is not counted, only the ticks after it was left
  logic [15:0] tick_r, tick_nxt, idle_r, idle_nxt;
  logic        seen_r, seen_nxt;
  assign tick_nxt = (clr_w || stby_w) ? 16'h0000 : tick_r + 16'(mclk_tick);
  assign seen_nxt = clr_w ? 1'b0 : (seen_r || stby_w);
  // Saturates so that a long power-down cannot wrap it
  assign idle_nxt = regs_ready ? 16'h0000 : idle_r + 16'(idle_r != 16'hffff);
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tick_r <= 16'h0000;
      seen_r <= 1'b0;
      idle_r <= 16'h0000;
    end else begin
      tick_r <= tick_nxt;
      seen_r <= seen_nxt;
      idle_r <= idle_nxt;
    end
  end

  a_code_format: assert property (
    code_valid |-> code_out == $past(code_w))
    else $error("code_out not formatted from sample");
  a_bias_write: assert property (
    bias_w |-> ##2 24'(bias_enable_bits) == ($past(reg_wdata, 2) & 24'h00ffff))
    else $error("bias bits do not follow write");
  a_gp_write: assert property (
    exc_w |-> ##2 {gp_out_value, gp_out_oe} == ($past(reg_wdata, 2) >> 16))
    else $error("outputs do not follow write");
  a_levels_off: assert property (
    !conv_run [*2] |-> current_a_level == 3'h0 && current_b_level == 3'h0)
    else $error("current on while not converting");
  a_down_float: assert property (
    !regs_ready [*2] |-> gp_out_oe == 4'h0 && !clk_pin_oe)
    else $error("pin driven while registers lost");
  a_wake_wait: assert property (
    $rose(conv_run) && seen_r |-> tick_r >= 16'h0081 && tick_r <= 16'h0083)
    else $error("standby exit not 130 master clocks");
  a_por_ready: assert property (
    $rose(regs_ready) |-> por_flag && idle_r >= 16'(WAKE_SETTLE_CYC - 1))
    else $error("ready without flag or too early");
  a_diag_block: assert property (
    $rose(diag_mclk_req) && stby_w && !conv_run |=> !diag_mclk_run [*3])
    else $error("diagnostic ran from standby");
endmodule : adcpc_ctrl_asserts

bind adcpc_ctrl adcpc_ctrl_asserts #(
  .WAKE_SETTLE_CYC(WAKE_SETTLE_CYC)
) u_chk (
  .clk, .sys_rst, .reg_wr, .reg_addr, .reg_wdata, .regs_ready, .por_flag,
  .clk_pin_oe, .mclk_tick, .conv_sample, .conv_bipolar, .code_out,
  .code_valid, .current_a_level, .current_b_level, .bias_enable_bits,
  .mode_out, .conv_run, .gp_out_value, .gp_out_oe, .diag_mclk_req,
  .diag_mclk_run
);

// ### bench/adcpc_host.sv
`timescale 1ns/10ps
module adcpc_host (
  // Output pins of the device
  input  wire logic [3:0] gp_out_value,
  input  wire logic [3:0] gp_out_oe,
  input  wire logic [3:0] short_mask,
  output logic      [3:0] gp_pin_in,
  // Serial pins
  output logic            sclk_pin,
  output logic            cs_n_pin,
  output logic            din_pin
);
  // Floating pins sit on pull-downs; a short holds a pin low
  assign gp_pin_in = gp_out_oe & gp_out_value & ~short_mask;
  initial begin
    sclk_pin = 1'b1;
    cs_n_pin = 1'b1;
    din_pin  = 1'b0;
  end
  // Phases of 4 clk cycles keep each level visible through the sync
  task automatic send_ones(input int n);
    cs_n_pin = 1'b0;
    din_pin  = 1'b1;
    repeat (n) begin
      #200 sclk_pin = 1'b0;
      #200 sclk_pin = 1'b1;
    end
    #200 cs_n_pin = 1'b1;
    din_pin = 1'b0;
  endtask : send_ones
endmodule : adcpc_host

// ### bench/adcpc_tb_top.sv
`timescale 1ns/10ps
module adcpc_tb_top;
  localparam int SETTLE = 50;
  logic clk, sys_rst, reg_wr, reg_rd, reg_rvalid, regs_ready, por_flag;
  logic por_flag_clr, sclk_pin, cs_n_pin, din_pin, clk_pin_oe, mclk_tick;
  logic conv_bipolar, conv_valid, code_valid, bridge_switch_on, ref_enable;
  logic conv_run, diag_mclk_req, diag_mclk_run, ext_run, clk_pin_out;
  logic [4:0]  ctrl_flags;
  logic        ext_clk_pin = 1'b0;
  logic [2:0]  current_a_level, current_b_level;
  logic [3:0]  current_a_pin_sel, current_b_pin_sel, mode_out;
  logic [3:0]  gp_out_value, gp_out_oe, gp_pin_in, short_mask;
  logic [5:0]  reg_addr;
  logic [15:0] bias_enable_bits;
  logic [23:0] reg_wdata, reg_rdata, conv_sample, code_out;
  logic [23:0] smp [4] = '{24'h000000, 24'h800000, 24'hffffff, 24'h7fffff};
  // Ticks in 500 us at 76.8, 153.6 and 614.4 kHz, one either side
  int          lo [3] = '{37, 75, 306};
  int          hi [3] = '{40, 78, 309};
  int          bad_count, n_tests, k, c;

  adcpc_ctrl #(.WAKE_SETTLE_CYC(SETTLE)) u_dut (
    .clk, .sys_rst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
    .reg_rvalid, .regs_ready, .por_flag, .por_flag_clr, .sclk_pin,
    .cs_n_pin, .din_pin, .ext_clk_pin, .clk_pin_out, .clk_pin_oe,
    .mclk_tick, .conv_sample, .conv_bipolar, .conv_valid, .code_out,
    .code_valid, .current_a_level, .current_b_level, .current_a_pin_sel,
    .current_b_pin_sel, .bridge_switch_on, .bias_enable_bits, .ref_enable,
    .ctrl_flags, .mode_out, .conv_run, .gp_out_value, .gp_out_oe,
    .gp_pin_in, .diag_mclk_req, .diag_mclk_run);
  adcpc_host u_host (.gp_out_value, .gp_out_oe, .short_mask, .gp_pin_in,
    .sclk_pin, .cs_n_pin, .din_pin);

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always #237 ext_clk_pin = ext_run ? ~ext_clk_pin : ext_clk_pin;

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic chk(input string w, input logic [23:0] e, logic [23:0] g);
    n_tests++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch %s exp %h got %h", w, e, g);
    end
  endtask : chk
  task automatic chk_rng(input string w, input int l, int h, int g);
    n_tests++;
    if (g < l || g > h) begin
      bad_count++;
      $display("mismatch %s exp %0d..%0d got %0d", w, l, h, g);
    end
  endtask : chk_rng
  task automatic wr(input logic [5:0] a, input logic [23:0] d);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    tick(1);
    reg_wr = 1'b0;
    tick(1);
  endtask : wr
  task automatic rdc(input string w, input logic [5:0] a, logic [23:0] e);
    reg_rd = 1'b1;
    reg_addr = a;
    tick(1);
    reg_rd = 1'b0;
    chk("rvalid", 24'h1, reg_rvalid);
    chk(w, e, reg_rdata);
    tick(1);
  endtask : rdc
  task automatic ticks(input int n, output int t);
    t = 0;
    repeat (n) begin
      tick(1);
      t += int'(mclk_tick === 1'b1);
    end
  endtask : ticks
  task automatic wait_ready(output int t);
    t = 0;
    while (regs_ready !== 1'b1 && t < 5000) begin
      tick(1);
      t++;
    end
  endtask : wait_ready
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : finish_test

  initial begin
    #5_000_000;
    bad_count++;
    $display("mismatch watchdog exp done got hang");
    finish_test();
  end

  initial begin
    {sys_rst, reg_wr, reg_rd, reg_addr, reg_wdata, por_flag_clr} = '0;
    {conv_sample, conv_bipolar, conv_valid, short_mask} = '0;
    {diag_mclk_req, ext_run, bad_count, n_tests} = '0;
    sys_rst = 1'b1;
    tick(10);
    sys_rst = 1'b0;
    wait_ready(k);
    chk_rng("settle", SETTLE - 1, SETTLE + 2, k);
    chk("por", 24'h1, por_flag);
    rdc("conv rst", 6'h01, 24'h000000);
    rdc("exc rst", 6'h03, 24'h000000);
    rdc("bias rst", 6'h04, 24'h000000);
    wr(6'h02, 24'hffffff);
    rdc("unmapped", 6'h02, 24'h000000);
    for (k = 0; k < 3; k++) begin
      wr(6'h01, 24'(k << 6));
      tick(2);
      ticks(10000, c);
      chk_rng("mclk", lo[k], hi[k], c);
    end
    wr(6'h01, 24'h000082);
    ticks(1000, c);
    chk_rng("ext stopped", 0, 0, c);
    ext_run = 1'b1;
    ticks(2000, c);
    chk_rng("ext running", 1, 2000, c);
    ext_run = 1'b0;
    wr(6'h01, 24'h000081);
    tick(2);
    chk("clk oe", 24'h1, clk_pin_oe);
    c = 0;
    repeat (1000) begin
      k = clk_pin_out;
      tick(1);
      c += int'(clk_pin_out === 1'b1 && k == 0);
    end
    chk_rng("clk pin", 30, 32, c);
    wr(6'h01, 24'h00ffcf);
    rdc("pd refused", 6'h01, 24'h001fc3);
    chk("flags mode", 24'h1f0, {ctrl_flags, mode_out});
    wr(6'h01, 24'h000081);
    // Reference stays disabled through all current checks
    for (k = 1; k < 7; k++) begin
      wr(6'h03, {8'haf, 2'b10, 3'(7 - k), 3'(k), 8'h55});
      tick(2);
      chk("currents", {3'(7 - k), 3'(k), 8'h55}, {current_b_level,
          current_a_level, current_b_pin_sel, current_a_pin_sel});
    end
    chk("ref off", 24'h0, ref_enable);
    chk("bridge gp", 24'h1af,
        {bridge_switch_on, gp_out_value, gp_out_oe});
    short_mask = 4'h2;
    tick(6);
    rdc("gp sense", 6'h03, 24'h8f8e55);
    short_mask = 4'h0;
    wr(6'h04, 24'h008001);
    tick(2);
    chk("bias", 24'h008001, bias_enable_bits);
    rdc("bias rd", 6'h04, 24'h008001);
    wr(6'h01, 24'h000081);
    for (k = 0; k < 8; k++) begin
      conv_sample = smp[k % 4];
      conv_bipolar = k > 3;
      conv_valid = 1'b1;
      tick(1);
      conv_valid = 1'b0;
      chk("code", smp[k % 4] ^ {k > 3, 23'h0},
          code_out);
      chk("code valid", 24'h1, code_valid);
      tick(1);
    end
    diag_mclk_req = 1'b1;
    tick(4);
    chk("diag active", 24'h1, diag_mclk_run);
    diag_mclk_req = 1'b0;
    wr(6'h01, 24'h000089);
    tick(3);
    chk("stby off", 24'h0,
        {conv_run, current_b_level, current_a_level});
    chk("stby keep", 24'h1af01,
        {bridge_switch_on, gp_out_value, gp_out_oe, bias_enable_bits[7:0]});
    rdc("stby regs", 6'h03, 24'haf8e55);
    diag_mclk_req = 1'b1;
    tick(4);
    chk("diag stby", 24'h0, diag_mclk_run);
    diag_mclk_req = 1'b0;
    wr(6'h01, 24'h000081);
    c = 0;
    k = 0;
    while (conv_run !== 1'b1 && k < 20000) begin
      tick(1);
      k++;
      c += int'(mclk_tick === 1'b1);
    end
    chk_rng("wake ticks", 129, 131, c);
    tick(2);
    chk("levels back", 24'h0e, {current_b_level, current_a_level});
    wr(6'h01, 24'h000089);
    tick(3);
    wr(6'h01, 24'h00008d);
    tick(3);
    chk("down", 24'h0,
        {regs_ready, gp_out_oe, clk_pin_oe, por_flag});
    u_host.send_ones(40);
    tick(20);
    chk("partial wake", 24'h0, regs_ready);
    u_host.send_ones(64);
    wait_ready(k);
    chk_rng("pd settle", SETTLE - 6, SETTLE + 6, k);
    chk("por wake", 24'h1, por_flag);
    rdc("pd conv", 6'h01, 24'h000000);
    rdc("pd exc", 6'h03, 24'h000000);
    rdc("pd bias", 6'h04, 24'h000000);
    por_flag_clr = 1'b1;
    tick(1);
    por_flag_clr = 1'b0;
    tick(1);
    chk("por clr", 24'h0, por_flag);
    finish_test();
  end
endmodule : adcpc_tb_top
